// File: logic/spc_pkg.sv
// constants and types for the stack power-state command block
package spc_pkg;
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  ADDR_ALL      = 4'hf;
    localparam logic [3:0]  ADDR_NONE     = 4'h0;
    localparam int          CMD_W         = 3;
    localparam logic [2:0]  CMD_SLEEP     = 3'h1;
    localparam logic [2:0]  CMD_WAKE      = 3'h2;
    localparam logic [2:0]  CMD_RESET     = 3'h3;
    localparam logic [2:0]  CMD_BAL_EN    = 3'h4;
    localparam int          CLK_MHZ       = 250;
    localparam int          SLEEP_WAIT_US_500K = 500;
    localparam int          SLEEP_WAIT_US_250K = 1000;
    localparam int          SLEEP_WAIT_US_125K = 2000;
    localparam int          SLEEP_WAIT_US_62K  = 4000;
    localparam int          WAKE_TONE_HZ  = 4000;
    localparam int          WAKE_TONE_CYC = 4;
    localparam int          TOP_ACK_US    = 4000;
    localparam int          CNT_W         = 24;
    localparam logic [23:0] CNT_ZERO      = 24'h000000;
    localparam logic [23:0] CNT_ONE       = 24'h000001;
    typedef enum logic [1:0] {
        SPC_RATE_500K,
        SPC_RATE_250K,
        SPC_RATE_125K,
        SPC_RATE_62K
    } spc_rate_e;
    typedef enum logic [2:0] {
        SPC_AWAKE,
        SPC_SLEEP_WAIT,
        SPC_ASLEEP,
        SPC_WAKE_TX,
        SPC_TOP_WAIT
    } spc_state_e;
endpackage

// File: logic/spc_core.sv
// power-state, reset and balance-enable command interpreter
`timescale 1ns/100ps
`default_nettype none
module spc_core
    import spc_pkg::*;
#(
    parameter int SLEEP_WAIT_US = SLEEP_WAIT_US_500K,
    parameter int TOP_ACK_WAIT_US = TOP_ACK_US
)(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              cmd_valid,
    input  wire logic [CMD_W-1:0]  cmd_code,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic              host_rx_valid,
    input  wire logic              wake_tone_in,
    input  wire logic              is_master,
    input  wire logic              is_top,
    input  wire logic              wdog_enable,
    input  wire logic              wdog_expired,
    input  wire logic              bal_config_ok,
    input  wire logic              ident_valid,
    input  wire logic [ADDR_W-1:0] ident_addr,
    input  wire logic [ADDR_W-1:0] ident_size,
    output logic                   ack_pulse,
    output logic                   nak_pulse,
    output logic                   asleep,
    output logic                   wake_tone_out,
    output logic                   host_rx_block,
    output logic                   comm_fault_check_en,
    output logic                   soft_reset_pulse,
    output logic                   balance_enable_bit,
    output logic [ADDR_W-1:0]      stack_addr,
    output logic [ADDR_W-1:0]      stack_size
);
    // ********************************************************
    // timing counts
    // ********************************************************
    // longest time rounds down; keep default below the chosen rate's bound
    localparam int SLEEP_CYC = SLEEP_WAIT_US * CLK_MHZ;
    localparam int HALF_TONE_CYC = (CLK_MHZ * 1000000) / (2 * WAKE_TONE_HZ);
    localparam int TONE_CYC = HALF_TONE_CYC * 2 * WAKE_TONE_CYC;
    localparam int TOP_ACK_CYC = TOP_ACK_WAIT_US * CLK_MHZ;

    function automatic logic [CNT_W-1:0] to_cnt(input int n);
        to_cnt = CNT_W'(n);
    endfunction

    // ********************************************************
    // command decode
    // ********************************************************
    logic is_bcast;
    logic is_mine;
    logic host_rx_ok;
    spc_state_e state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] tone_div_r;

    assign is_bcast = (cmd_addr == ADDR_ALL);
    assign is_mine  = (cmd_addr == stack_addr) && !is_bcast;
    assign host_rx_block = (state_r == SPC_WAKE_TX);
    assign host_rx_ok = !host_rx_block;
    // waking and asleep never raise a communication fault
    assign comm_fault_check_en = (state_r == SPC_AWAKE);
    assign asleep = (state_r == SPC_ASLEEP);

    logic sleep_cmd;
    logic wake_cmd;
    logic rst_cmd;
    logic ben_cmd;
    assign sleep_cmd = cmd_valid && host_rx_ok && (cmd_code == CMD_SLEEP);
    assign wake_cmd  = cmd_valid && host_rx_ok && (cmd_code == CMD_WAKE);
    assign rst_cmd   = cmd_valid && host_rx_ok && (cmd_code == CMD_RESET);
    assign ben_cmd   = cmd_valid && host_rx_ok && (cmd_code == CMD_BAL_EN);

    // ********************************************************
    // power-state machine
    // ********************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= SPC_AWAKE;
            cnt_r   <= CNT_ZERO;
        end
        else
        begin
            unique case (state_r)
                SPC_AWAKE:
                begin
                    // no identification needed for sleep
                    if (sleep_cmd && is_bcast)
                    begin
                        state_r <= SPC_SLEEP_WAIT;
                        cnt_r   <= to_cnt(SLEEP_CYC);
                    end
                    else if (wdog_enable && wdog_expired)
                        state_r <= SPC_ASLEEP;
                end
                SPC_SLEEP_WAIT:
                begin
                    if (sleep_cmd && is_bcast)
                        cnt_r <= to_cnt(SLEEP_CYC);
                    else if (cmd_valid || host_rx_valid)
                        state_r <= SPC_AWAKE;
                    else if (cnt_r == CNT_ONE)
                        state_r <= SPC_ASLEEP;
                    else
                        cnt_r <= cnt_r - CNT_ONE;
                end
                SPC_ASLEEP:
                begin
                    // only a broadcast wake on the master or an incoming tone wakes us
                    if ((wake_cmd && is_bcast && is_master) || wake_tone_in)
                    begin
                        state_r <= is_top ? SPC_TOP_WAIT : SPC_WAKE_TX;
                        cnt_r   <= is_top ? to_cnt(TOP_ACK_CYC) : to_cnt(TONE_CYC);
                    end
                end
                SPC_WAKE_TX:
                begin
                    if (cnt_r == CNT_ONE)
                        state_r <= SPC_AWAKE;
                    else
                        cnt_r <= cnt_r - CNT_ONE;
                end
                SPC_TOP_WAIT:
                begin
                    if (cnt_r == CNT_ONE)
                        state_r <= SPC_AWAKE;
                    else
                        cnt_r <= cnt_r - CNT_ONE;
                end
            endcase
        end
    end

    // ********************************************************
    // wake tone generator
    // ********************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tone_div_r    <= CNT_ZERO;
            wake_tone_out <= 1'b0;
        end
        else if (state_r != SPC_WAKE_TX)
        begin
            tone_div_r    <= CNT_ZERO;
            wake_tone_out <= 1'b0;
        end
        else if (tone_div_r == to_cnt(HALF_TONE_CYC - 1))
        begin
            tone_div_r    <= CNT_ZERO;
            wake_tone_out <= !wake_tone_out;
        end
        else
            tone_div_r <= tone_div_r + CNT_ONE;
    end

    // ********************************************************
    // acknowledges
    // ********************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_pulse <= 1'b0;
            nak_pulse <= 1'b0;
        end
        else
        begin
            ack_pulse <= (state_r == SPC_AWAKE && sleep_cmd && is_bcast && is_top)
                      || (state_r == SPC_TOP_WAIT && cnt_r == CNT_ONE);
            // master may be unidentified, so any non-broadcast wake is refused
            nak_pulse <= (sleep_cmd && is_mine)
                      || (wake_cmd && !is_bcast && is_master);
        end
    end

    // ********************************************************
    // reset, addressing and balance enable
    // ********************************************************
    logic do_reset;
    // broadcast reset has no effect and nothing is answered
    assign do_reset = rst_cmd && is_mine && state_r != SPC_ASLEEP;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            soft_reset_pulse <= 1'b0;
        else
            soft_reset_pulse <= do_reset;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stack_addr <= ADDR_NONE;
            stack_size <= ADDR_NONE;
        end
        else if (do_reset)
        begin
            stack_addr <= ADDR_NONE;
            stack_size <= ADDR_NONE;
        end
        else if (ident_valid)
        begin
            stack_addr <= ident_addr;
            stack_size <= ident_size;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            balance_enable_bit <= 1'b0;
        else if (do_reset)
            balance_enable_bit <= 1'b0;
        else if (ben_cmd && (is_bcast || is_mine) && bal_config_ok)
            balance_enable_bit <= 1'b1;
    end

    // ********************************************************
    // checks
    // ********************************************************
    a_tone_blocks_host: assert property (@(posedge clk) disable iff (!rstn)
        wake_tone_out |-> host_rx_block) else $error("tone sent while host rx open");
    a_unicast_sleep_nak: assert property (@(posedge clk) disable iff (!rstn)
        (sleep_cmd && is_mine) |=> nak_pulse) else $error("missing sleep nak");
    a_unicast_sleep_stay: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == SPC_AWAKE && sleep_cmd && is_mine && !(wdog_enable && wdog_expired))
        |=> state_r == SPC_AWAKE) else $error("unicast sleep acted on");
    a_top_sleep_ack: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == SPC_AWAKE && sleep_cmd && is_bcast && is_top) |=> ack_pulse)
        else $error("top missed sleep ack");
    a_sleep_abort: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == SPC_SLEEP_WAIT && host_rx_valid && !sleep_cmd) |=> state_r == SPC_AWAKE)
        else $error("sleep not aborted");
    a_sleep_restart: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == SPC_SLEEP_WAIT && sleep_cmd && is_bcast) |=> cnt_r == to_cnt(SLEEP_CYC))
        else $error("sleep wait not restarted");
    a_sleep_leave: assert property (@(posedge clk) disable iff (!rstn)
        (asleep && !wake_tone_in && !(wake_cmd && is_bcast && is_master)) |=> asleep)
        else $error("left sleep without wake");
    a_reset_clears_addr: assert property (@(posedge clk) disable iff (!rstn)
        do_reset |=> (stack_addr == ADDR_NONE && stack_size == ADDR_NONE && !balance_enable_bit))
        else $error("reset left state");
    a_bcast_reset_ignored: assert property (@(posedge clk) disable iff (!rstn)
        (rst_cmd && is_bcast) |=> !soft_reset_pulse) else $error("broadcast reset acted");
    a_ben_needs_config: assert property (@(posedge clk) disable iff (!rstn)
        $rose(balance_enable_bit) |-> $past(bal_config_ok)) else $error("ben without config");
    a_wdog_sleep: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == SPC_AWAKE && !sleep_cmd && wdog_enable && wdog_expired) |=> asleep)
        else $error("watchdog sleep missed");
    a_wake_nak_master: assert property (@(posedge clk) disable iff (!rstn)
        (wake_cmd && !is_bcast && is_master) |=> nak_pulse)
        else $error("missing wake nak");
    a_top_wake_ack: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == SPC_TOP_WAIT && cnt_r == CNT_ONE) |=> (ack_pulse && state_r == SPC_AWAKE))
        else $error("top wake ack missing");
    a_sleep_wait_bound: assert property (@(posedge clk) disable iff (!rstn)
        state_r == SPC_SLEEP_WAIT |-> (cnt_r <= to_cnt(SLEEP_CYC) && cnt_r != CNT_ZERO))
        else $error("sleep wait out of bound");
    a_bcast_ben: assert property (@(posedge clk) disable iff (!rstn)
        (ben_cmd && is_bcast && bal_config_ok) |=> balance_enable_bit)
        else $error("broadcast balance enable lost");
    a_master_wake_tone: assert property (@(posedge clk) disable iff (!rstn)
        (asleep && wake_cmd && is_bcast && is_master && !is_top) |=> host_rx_block)
        else $error("master did not start tone");
    a_tone_wakes: assert property (@(posedge clk) disable iff (!rstn)
        (asleep && wake_tone_in) |=> !asleep)
        else $error("tone did not wake");
endmodule
`default_nettype wire

// File: testbench/spc_far_end.sv
// far-side model: host controller and neighbouring stack devices
`timescale 1ns/100ps
`default_nettype none
// ************************************************
// frame and tone driver
// ************************************************
module spc_far_end
    import spc_pkg::*;
(
    input  wire logic              clk,
    output logic                   cmd_valid,
    output logic [CMD_W-1:0]       cmd_code,
    output logic [ADDR_W-1:0]      cmd_addr,
    output logic                   host_rx_valid,
    output logic                   wake_tone_in
);
    initial
    begin
        {cmd_valid, cmd_code, cmd_addr, host_rx_valid, wake_tone_in} = '0;
    end

    // one frame per cycle; host is meant to broadcast sleep and wake
    task automatic send(input logic [CMD_W-1:0] c, input logic [ADDR_W-1:0] a);
        @(negedge clk);
        {cmd_valid, cmd_code, cmd_addr} = {1'b1, c, a};
        @(negedge clk);
        cmd_valid = 1'b0;
        // stale fields would hide a missing qualifier check
        {cmd_code, cmd_addr} = ~{c, a};
    endtask

    // any other valid host-port frame
    task automatic rx();
        @(negedge clk);
        host_rx_valid = 1'b1;
        @(negedge clk);
        host_rx_valid = 1'b0;
    endtask

    // wake tone from the device below; detector only sees the level
    task automatic tone(input int n);
        @(negedge clk);
        wake_tone_in = 1'b1;
        repeat (n) @(negedge clk);
        wake_tone_in = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the power-state command block
`timescale 1ns/100ps
`default_nettype none
// ************************************************
// bench top
// ************************************************
module tb;
    import spc_pkg::*;
    localparam int SLP = 250;  // 1 us waits at 250 MHz
    logic        clk, rstn, is_master, is_top, wdog_enable, wdog_expired;
    logic        bal_config_ok, ident_valid, ack_pulse, nak_pulse, asleep;
    logic        wake_tone_out, host_rx_block, comm_fault_check_en;
    logic        soft_reset_pulse, balance_enable_bit, cmd_valid;
    logic        host_rx_valid, wake_tone_in, e_bal, e_blk, v;
    logic [2:0]  cmd_code;
    logic [3:0]  cmd_addr, ident_addr, ident_size, stack_addr, stack_size;
    logic [3:0]  e_addr, e_size;
    int          err_count, n_checks, n_ack, n_nak, n_srst, e_ack, e_nak;
    int          e_srst, t;

    spc_far_end far_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_addr(cmd_addr), .host_rx_valid(host_rx_valid), .wake_tone_in(wake_tone_in));
    spc_core #(.SLEEP_WAIT_US(1), .TOP_ACK_WAIT_US(1)) dut_u (.clk(clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .host_rx_valid(host_rx_valid), .wake_tone_in(wake_tone_in),
        .is_master(is_master), .is_top(is_top), .wdog_enable(wdog_enable),
        .wdog_expired(wdog_expired), .bal_config_ok(bal_config_ok),
        .ident_valid(ident_valid), .ident_addr(ident_addr), .ident_size(ident_size),
        .ack_pulse(ack_pulse), .nak_pulse(nak_pulse), .asleep(asleep),
        .wake_tone_out(wake_tone_out), .host_rx_block(host_rx_block),
        .comm_fault_check_en(comm_fault_check_en), .soft_reset_pulse(soft_reset_pulse),
        .balance_enable_bit(balance_enable_bit), .stack_addr(stack_addr),
        .stack_size(stack_size));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // pulses counted, so a one-cycle slip in answer latency still matches
    always @(posedge clk)
    begin
        n_ack  += int'(ack_pulse === 1'b1);
        n_nak  += int'(nak_pulse === 1'b1);
        n_srst += int'(soft_reset_pulse === 1'b1);
    end

    task automatic bad(input string m);
        err_count++;
        $display("BAD t=%0t %s", $time, m);
    endtask
    task automatic chk_bit(input logic g, input logic e);
        n_checks++;
        if (g !== e) bad("flag mismatch");
    endtask
    task automatic chk_nib(input logic [3:0] g, input logic [3:0] e);
        n_checks++;
        if (g !== e) bad("field mismatch");
    endtask
    task automatic chk_cnt(input int g, input int e);
        n_checks++;
        if (g != e) bad("pulse count mismatch");
    endtask

    // reference model of the command decode
    task automatic cmd(input logic [2:0] c, input logic [3:0] a);
        far_u.send(c, a);
        if (!e_blk && c == CMD_SLEEP) begin
            if (a == e_addr) e_nak++;
            else if (a == ADDR_ALL && is_top) e_ack++;
        end
        if (!e_blk && c == CMD_WAKE && a != ADDR_ALL && is_master) e_nak++;
        if (!e_blk && c == CMD_RESET && a == e_addr) begin
            e_srst++;
            {e_bal, e_addr, e_size} = '0;
        end
        if (!e_blk && c == CMD_BAL_EN && bal_config_ok && (a == ADDR_ALL || a == e_addr))
            e_bal = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    task automatic check_all();
        chk_cnt(n_ack, e_ack);
        chk_cnt(n_nak, e_nak);
        chk_cnt(n_srst, e_srst);
        chk_bit(balance_enable_bit, e_bal);
        chk_nib(stack_addr, e_addr);
        chk_nib(stack_size, e_size);
    endtask

    task automatic do_reset();
        @(negedge clk);
        rstn = 1'b0;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        {e_bal, e_blk, e_addr, e_size} = '0;
        cmd(CMD_RESET, ADDR_NONE);
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // whole run is about 33k cycles
    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end

    initial
    begin
        {rstn, is_master, is_top, wdog_enable, wdog_expired} = '0;
        {bal_config_ok, ident_valid, ident_addr, ident_size} = '0;
        {n_ack, n_nak, n_srst, e_ack, e_nak, e_srst, err_count, n_checks} = '0;
        void'($urandom(32'h29e1));
        do_reset();
        chk_bit(comm_fault_check_en, 1'b1);
        check_all();
        cmd(CMD_SLEEP, ADDR_ALL);
        repeat (SLP - 60) @(negedge clk);
        cmd(CMD_SLEEP, ADDR_ALL);
        repeat (SLP - 60) @(negedge clk);
        chk_bit(asleep, 1'b0);
        repeat (70) @(negedge clk);
        chk_bit(asleep, 1'b1);
        far_u.rx();
        chk_bit(asleep, 1'b1);
        chk_bit(comm_fault_check_en, 1'b0);
        do_reset();
        e_addr = 4'($urandom_range(14, 1));
        e_size = 4'($urandom_range(14, 1));
        @(negedge clk);
        {ident_valid, ident_addr, ident_size} = {1'b1, e_addr, e_size};
        @(negedge clk);
        ident_valid = 1'b0;
        cmd(CMD_SLEEP, e_addr);
        check_all();
        cmd(CMD_SLEEP, ADDR_ALL);
        repeat ($urandom_range(200, 1)) @(negedge clk);
        far_u.rx();
        repeat (SLP + 20) @(negedge clk);
        chk_bit(asleep, 1'b0);
        cmd(CMD_BAL_EN, ADDR_ALL);
        check_all();
        bal_config_ok = 1'b1;
        cmd(CMD_BAL_EN, ADDR_ALL);
        check_all();
        cmd(CMD_RESET, ADDR_ALL);
        check_all();
        cmd(CMD_RESET, e_addr);
        check_all();
        // watchdog: no effect unless enabled
        for (int i = 0; i < 2; i++) begin
            wdog_enable = 1'(i);
            wdog_expired = 1'b1;
            repeat (3) @(negedge clk);
            wdog_expired = 1'b0;
            repeat (3) @(negedge clk);
            chk_bit(asleep, 1'(i));
        end
        do_reset();
        is_top = 1'b1;
        cmd(CMD_SLEEP, ADDR_ALL);
        check_all();
        repeat (SLP + 10) @(negedge clk);
        chk_bit(asleep, 1'b1);
        far_u.tone(8);
        t = 0;
        while (n_ack == e_ack && t < 1000) begin
            @(negedge clk);
            t++;
        end
        e_ack++;
        chk_bit(asleep, 1'b0);
        chk_cnt(n_ack, e_ack);
        chk_bit(t >= SLP - 30 && t <= SLP + 20, 1'b1);
        // master wake: tone would run long, so one toggle is checked and the run finishes
        do_reset();
        {is_top, is_master} = 2'b01;
        cmd(CMD_SLEEP, ADDR_ALL);
        repeat (SLP + 10) @(negedge clk);
        cmd(CMD_WAKE, 4'h3);
        check_all();
        chk_bit(asleep, 1'b1);
        cmd(CMD_WAKE, ADDR_ALL);
        chk_bit(asleep, 1'b0);
        chk_bit(host_rx_block, 1'b1);
        chk_bit(comm_fault_check_en, 1'b0);
        e_blk = 1'b1;
        cmd(CMD_SLEEP, 4'h3);
        check_all();
        v = wake_tone_out;
        repeat (31300) @(negedge clk);
        chk_bit(wake_tone_out, ~v);
        give_verdict();
    end
endmodule
`default_nettype wire
